//--- hw/ssd_pkg.sv
// constants shared by the spi status and data path
package ssd_pkg;
	// register addresses on the sfr bus
	localparam logic [7:0] ADDR_STATUS = 8'hf4;
	localparam logic [7:0] ADDR_DATA   = 8'hf5;
	// status bit positions
	localparam int BIT_DONE = 7;
	localparam int BIT_WRITE_COLLISION_FLAG = 6;
	localparam int BIT_OVF  = 5;
	localparam int BIT_MODE_FAULT_FLAG = 4;
	localparam int BIT_DIS  = 3;
	localparam int BIT_TXF  = 2;
	// reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_DATA   = 8'h00;
	// bits in one byte transfer
	localparam int BYTE_BITS = 8;
	// default system clocks per half serial clock in master mode
	localparam int SCK_HALF_DEF = 4;
	// transfer engine states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_MXFER = 3'b010,
		ST_SXFER = 3'b100
	} ssd_state_t;
endpackage : ssd_pkg

//--- hw/ssd_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssd_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;  // first stage, read only by second stage
	logic [W-1:0] meta_nxt;
	logic [W-1:0] dout_nxt;

	// next values: plain shift through two stages
	always_comb begin
		meta_nxt = din;
		dout_nxt = meta_r;
	end

	// register both stages; pins idle high after reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '1;
			dout   <= '1;
		end else begin
			meta_r <= meta_nxt;
			dout   <= dout_nxt;
		end
	end
endmodule : ssd_sync

//--- hw/ssd_core.sv
// spi status flags, data register and byte shift engine
`timescale 1ns/1ps
module ssd_core
	import ssd_pkg::*;
#(
	parameter int SCK_HALF = ssd_pkg::SCK_HALF_DEF
) (
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       master_select,
	input  wire logic       select_output_enable,
	input  wire logic       spi_irq_enable,
	input  wire logic       global_irq_enable,
	output logic            spi_irq,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe_n,
	input  wire logic       mosi_in,
	output logic            mosi_out,
	output logic            mosi_oe_n,
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe_n,
	input  wire logic       ss_in_n,
	output logic            ss_out_n,
	output logic            ss_oe_n
);
	import ssd_pkg::*;

	localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);
	localparam logic [3:0] BIT_LAST  = 4'(BYTE_BITS - 1);

	// synchronised pins; sck enters inverted so it idles low from reset
	logic [3:0] pins_s;
	logic       sck_s;
	logic       mosi_s;
	logic       miso_s;
	logic       ss_s_n;

	ssd_sync #(.W(4)) u_sync (
		.clock  (clock),
		.arst_n (arst_n),
		.din    ({~sck_in, mosi_in, miso_in, ss_in_n}),
		.dout   (pins_s)
	);
	assign {sck_s, mosi_s, miso_s, ss_s_n} = pins_s ^ 4'b1000;

	ssd_state_t state_r, state_nxt;      // transfer engine state
	logic [7:0] shift_r, shift_nxt;      // transmit and receive shifter
	logic [7:0] rxbuf_r, rxbuf_nxt;      // receive read buffer
	logic [3:0] cnt_r, cnt_nxt;          // bits shifted this byte
	logic [7:0] half_r, half_nxt;        // master half period counter
	logic       bit_r, bit_nxt;          // sampled input bit
	logic       sckd_r, sckd_nxt;        // delayed sck for edge find
	logic       done_r, done_nxt;        // transfer_done_flag
	logic       write_collision_flag_r, write_collision_flag_nxt;        // write_collision_flag
	logic       ovf_r, ovf_nxt;          // rx_overrun_flag
	logic       mode_fault_flag_r, mode_fault_flag_nxt;        // mode_fault_flag
	logic       dis_r, dis_nxt;          // fault_detect_disable
	logic       txf_r, txf_nxt;          // tx_buffer_full
	logic [7:0] rdata_nxt;
	logic       irq_nxt;
	logic       sck_out_nxt, sck_oe_nxt, mosi_oe_nxt, miso_oe_nxt;
	logic       ss_out_nxt, ss_oe_nxt;

	// helper terms
	logic sck_rise, sck_fall, complete, busy, fault, wr_stat, wr_data;
	logic [7:0] status_byte, rx_byte;

	assign sck_rise = sck_s & ~sckd_r;
	assign sck_fall = ~sck_s & sckd_r;
	assign wr_stat  = sfr_wr && (sfr_addr == ADDR_STATUS);
	assign wr_data  = sfr_wr && (sfr_addr == ADDR_DATA);
	// a byte is in flight for the whole master transfer, or in slave once sck rose or bit 0 passed
	assign busy = (state_r == ST_MXFER) ||
		((state_r == ST_SXFER) && ((cnt_r != 4'h0) || sck_s));
	// select pin acts as fault input only in master with detect on
	assign fault = master_select && !dis_r && !ss_s_n;

	// status byte as software sees it, low two bits zero
	always_comb begin
		status_byte = 8'h00;
		status_byte[BIT_DONE] = done_r;
		status_byte[BIT_WRITE_COLLISION_FLAG] = write_collision_flag_r;
		status_byte[BIT_OVF]  = ovf_r;
		status_byte[BIT_MODE_FAULT_FLAG] = mode_fault_flag_r;
		status_byte[BIT_DIS]  = dis_r;
		status_byte[BIT_TXF]  = txf_r;
	end

	// next state of the whole engine, flags and sfr answer
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		rxbuf_nxt = rxbuf_r;
		cnt_nxt   = cnt_r;
		half_nxt  = half_r;
		bit_nxt   = bit_r;
		sckd_nxt  = sck_s;
		complete  = 1'b0;
		rx_byte   = {shift_r[6:0], bit_r};
		sck_out_nxt = sck_out;

		// byte shifting; bit taken on the rising edge, shifted on falling
		case (state_r)
			ST_IDLE: begin
				// slave armed as soon as the master selects us
				if (!master_select && !ss_s_n) begin
					state_nxt = ST_SXFER;
					cnt_nxt   = 4'h0;
				end
			end
			ST_MXFER: begin
				if (half_r == HALF_LAST) begin
					half_nxt = 8'h00;
					if (!sck_out) begin
						sck_out_nxt = 1'b1;
						bit_nxt     = miso_s;
					end else begin
						sck_out_nxt = 1'b0;
						shift_nxt   = rx_byte;
						cnt_nxt     = cnt_r + 4'h1;
						if (cnt_r == BIT_LAST) begin
							complete  = 1'b1;
							cnt_nxt   = 4'h0;
							state_nxt = ST_IDLE;
						end
					end
				end else begin
					half_nxt = half_r + 8'h01;
				end
			end
			ST_SXFER: begin
				if (ss_s_n || master_select) begin
					// deselect drops any partial byte
					state_nxt = ST_IDLE;
					cnt_nxt   = 4'h0;
				end else if (sck_rise) begin
					bit_nxt = mosi_s;
				end else if (sck_fall) begin
					shift_nxt = rx_byte;
					cnt_nxt   = cnt_r + 4'h1;
					if (cnt_r == BIT_LAST) begin
						complete = 1'b1;
						cnt_nxt  = 4'h0;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase

		// a mode fault stops the master at once and parks the clock
		if (fault && state_r == ST_MXFER) begin
			state_nxt   = ST_IDLE;
			sck_out_nxt = 1'b0;
			cnt_nxt     = 4'h0;
			half_nxt    = 8'h00;
		end

		// software clears by writing zero; a set in the same cycle wins
		done_nxt = done_r && !(wr_stat && !sfr_wdata[BIT_DONE]);
		write_collision_flag_nxt = write_collision_flag_r && !(wr_stat && !sfr_wdata[BIT_WRITE_COLLISION_FLAG]);
		ovf_nxt  = ovf_r && !(wr_stat && !sfr_wdata[BIT_OVF]);
		mode_fault_flag_nxt = mode_fault_flag_r && !(wr_stat && !sfr_wdata[BIT_MODE_FAULT_FLAG]);
		dis_nxt  = wr_stat ? sfr_wdata[BIT_DIS] : dis_r;
		txf_nxt  = txf_r;

		// end of byte: hand to read buffer unless previous unread
		if (complete) begin
			txf_nxt  = 1'b0;
			done_nxt = 1'b1;
			if (done_r) begin
				ovf_nxt = 1'b1;
			end else begin
				rxbuf_nxt = rx_byte;
			end
		end

		if (fault) begin
			mode_fault_flag_nxt = 1'b1;
		end

		// cpu write of the data byte
		if (wr_data) begin
			if (done_r) begin
				// dropped silently, shifter untouched
				shift_nxt = shift_nxt;
			end else if (busy) begin
				write_collision_flag_nxt = 1'b1;
			end else begin
				shift_nxt = sfr_wdata;
				txf_nxt   = 1'b1;
				if (master_select && !fault) begin
					state_nxt = ST_MXFER;
					cnt_nxt   = 4'h0;
					half_nxt  = 8'h00;
				end
			end
		end

		// read answer is held until the next read
		rdata_nxt = sfr_rdata;
		if (sfr_rd) begin
			if (sfr_addr == ADDR_STATUS) begin
				rdata_nxt = status_byte;
			end else if (sfr_addr == ADDR_DATA) begin
				rdata_nxt = rxbuf_r;
			end else begin
				rdata_nxt = 8'h00;
			end
		end

		irq_nxt = (done_r || ovf_r || mode_fault_flag_r) &&
			spi_irq_enable && global_irq_enable;

		// pin drivers; enables low while driving
		sck_oe_nxt  = !master_select;
		mosi_oe_nxt = !master_select;
		miso_oe_nxt = !(!master_select && state_r == ST_SXFER);
		// select pin only driven with detect off and output enable on
		ss_oe_nxt  = !(master_select && dis_r && select_output_enable);
		ss_out_nxt = !(state_nxt == ST_MXFER);
	end

	// register every piece of state and every output except mosi_out and miso_out
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= ST_IDLE;
			shift_r   <= RST_DATA;
			rxbuf_r   <= RST_DATA;
			cnt_r     <= 4'h0;
			half_r    <= 8'h00;
			bit_r     <= 1'b0;
			sckd_r    <= 1'b0;
			done_r    <= RST_STATUS[BIT_DONE];
			write_collision_flag_r    <= RST_STATUS[BIT_WRITE_COLLISION_FLAG];
			ovf_r     <= RST_STATUS[BIT_OVF];
			mode_fault_flag_r    <= RST_STATUS[BIT_MODE_FAULT_FLAG];
			dis_r     <= RST_STATUS[BIT_DIS];
			txf_r     <= RST_STATUS[BIT_TXF];
			sfr_rdata <= 8'h00;
			spi_irq   <= 1'b0;
			sck_out   <= 1'b0;
			sck_oe_n  <= 1'b1;
			mosi_oe_n <= 1'b1;
			miso_oe_n <= 1'b1;
			ss_out_n  <= 1'b1;
			ss_oe_n   <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			shift_r   <= shift_nxt;
			rxbuf_r   <= rxbuf_nxt;
			cnt_r     <= cnt_nxt;
			half_r    <= half_nxt;
			bit_r     <= bit_nxt;
			sckd_r    <= sckd_nxt;
			done_r    <= done_nxt;
			write_collision_flag_r    <= write_collision_flag_nxt;
			ovf_r     <= ovf_nxt;
			mode_fault_flag_r    <= mode_fault_flag_nxt;
			dis_r     <= dis_nxt;
			txf_r     <= txf_nxt;
			sfr_rdata <= rdata_nxt;
			spi_irq   <= irq_nxt;
			sck_out   <= sck_out_nxt;
			sck_oe_n  <= sck_oe_nxt;
			mosi_oe_n <= mosi_oe_nxt;
			miso_oe_n <= miso_oe_nxt;
			ss_out_n  <= ss_out_nxt;
			ss_oe_n   <= ss_oe_nxt;
		end
	end

	// serial data out is the shifter msb in either role
	assign mosi_out = shift_r[7];
	assign miso_out = shift_r[7];
endmodule : ssd_core

//--- testbench/ssd_sva.sv
// port checks for the spi status and data path
`timescale 1ns/1ps
module ssd_sva
	import ssd_pkg::*;
#(
	parameter int SCK_HALF = 4
) (
	input wire logic	clock,
	input wire logic	arst_n,
	input wire logic [7:0]	sfr_addr,
	input wire logic	sfr_rd,
	input wire logic [7:0]	sfr_rdata,
	input wire logic	spi_irq_enable,
	input wire logic	global_irq_enable,
	input wire logic	spi_irq,
	input wire logic	master_select,
	input wire logic	select_output_enable,
	input wire logic	sck_out,
	input wire logic	mosi_oe_n,
	input wire logic	ss_out_n,
	input wire logic	ss_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [7:0]	hi_r;	// samples sck has stayed high
	logic [7:0]	hi_nxt;
	// run length of a high half, cleared while low
	always_comb begin
		hi_nxt = sck_out ? hi_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			hi_r <= 8'h00;
		else
			hi_r <= hi_nxt;
	end
	irq_cause_a: assert property (
		spi_irq |-> $past(spi_irq_enable && global_irq_enable))
		else $error("irq without enables");
	irq_mask_a: assert property (
		!global_irq_enable |=> !spi_irq) else $error("irq not masked");
	sck_half_a: assert property (
		$fell(sck_out) |-> hi_r == 8'(SCK_HALF)) else $error("sck half");
	xfer_drive_a: assert property (
		!ss_out_n |-> !mosi_oe_n) else $error("mosi not driven");
	ss_drive_a: assert property (
		!ss_oe_n |-> $past(master_select && select_output_enable))
		else $error("select driven wrongly");
	ss_slave_a: assert property (
		!$past(master_select) |-> ss_oe_n) else $error("select in slave");
	rd_hold_a: assert property (
		!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
	rsvd_zero_a: assert property (
		sfr_rd && sfr_addr == ADDR_STATUS |=> sfr_rdata[1:0] == 2'b00)
		else $error("reserved bits set");
	irq_c: cover property ($rose(spi_irq));
	sck_c: cover property ($rose(sck_out));
	ss_c: cover property (!ss_oe_n);
endmodule : ssd_sva
bind ssd_core ssd_sva #(.SCK_HALF(SCK_HALF)) chk_u (.clock, .arst_n,
	.sfr_addr, .sfr_rd, .sfr_rdata, .spi_irq_enable, .global_irq_enable,
	.spi_irq, .master_select, .select_output_enable, .sck_out,
	.mosi_oe_n, .ss_out_n, .ss_oe_n);

//--- testbench/ssd_slave_model.sv
// behavioural mode 0 spi slave facing the master link
`timescale 1ns/1ps
module ssd_slave_model #(
	parameter logic [7:0] TX_BYTE = 8'h3c
) (
	input  wire logic	sck,
	input  wire logic	mosi,
	input  wire logic	sel_n,
	output logic		miso = 1'b0,
	output logic [7:0]	rx = 8'h00
);
	logic [7:0]	sh;	// outgoing byte
	// first bit must be out before the first rising edge
	always @(negedge sel_n) begin
		sh = TX_BYTE;
		miso = TX_BYTE[7];
	end
	always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!sel_n) begin
		sh = {sh[6:0], 1'b0};
		miso = sh[7];
	end
	// released line: flip, so a stale bit never reads as good
	always @(posedge sel_n) miso = ~miso;
endmodule : ssd_slave_model

//--- testbench/spi_status_and_data_path_tb.sv
// self-checking bench for the spi status and data path
`timescale 1ns/1ps
module spi_status_and_data_path_tb;
	import ssd_pkg::*;
	logic		clock = 1'b0;
	logic		arst_n = 1'b0;
	logic [7:0]	addr = 8'h00;
	logic [7:0]	wd = 8'h00;
	logic [7:0]	rdata, rx;
	logic		wr_s = 1'b0, rd_s = 1'b0, ms = 1'b0, soe = 1'b1;
	logic		ie = 1'b1, ge = 1'b1, irq, sck = 1'b0, mosi = 1'b0;
	logic		miso, ss_n = 1'b1, sck_o, mosi_o, sso_n, select_output_enable_n;
	logic		sckoe_n, mosioe_n, miso_o, misooe_n;
	int		miscompares = 0;
	int		num_checks = 0;
	always #50 clock = ~clock;
	ssd_core #(.SCK_HALF(4)) dut_u (.clock, .arst_n, .sfr_addr(addr),
		.sfr_wr(wr_s), .sfr_rd(rd_s), .sfr_wdata(wd), .sfr_rdata(rdata),
		.master_select(ms), .select_output_enable(soe),
		.spi_irq_enable(ie), .global_irq_enable(ge), .spi_irq(irq),
		.sck_in(sck), .sck_out(sck_o), .sck_oe_n(sckoe_n), .mosi_in(mosi),
		.mosi_out(mosi_o), .mosi_oe_n(mosioe_n), .miso_in(miso),
		.miso_out(miso_o), .miso_oe_n(misooe_n), .ss_in_n(ss_n),
		.ss_out_n(sso_n), .ss_oe_n(select_output_enable_n));
	ssd_slave_model peer_u (.sck(sck_o), .mosi(mosi_o), .sel_n(sso_n),
		.miso, .rx);
	task automatic chk(string n, logic [7:0] g, logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
	endtask : wr
	// read, then compare once the registered answer has settled
	task automatic rc(logic [7:0] a, logic [7:0] e, string n);
		@(posedge clock);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		@(negedge clock);
		chk(n, rdata, e);
	endtask : rc
	task automatic wirq();
		for (int i = 0; i < 300 && irq !== 1'b1; i++)
			@(negedge clock);
		chk("irq", {7'h00, irq}, 8'h01);
	endtask : wirq
	// one byte as link master, 800 ns per bit; miso taken before each fall
	task automatic sbyte(logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			mosi <= d[i];
			repeat (4) @(posedge clock);
			sck <= 1'b1;
			repeat (4) @(posedge clock);
			q[i] = miso_o;
			sck <= 1'b0;
		end
	endtask : sbyte
	task automatic t_reset();
		rc(ADDR_STATUS, RST_STATUS, "status");
		rc(ADDR_DATA, RST_DATA, "data");
		rc(8'h77, 8'h00, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_master();
		@(posedge clock);
		ms <= 1'b1;
		wr(ADDR_DATA, 8'ha5);
		rc(ADDR_STATUS, 8'h04, "txfull");
		chk("master oe", {5'h00, sckoe_n, mosioe_n, misooe_n}, 8'h01);
		wirq();
		rc(ADDR_STATUS, 8'h80, "done");
		chk("peer rx", rx, 8'ha5);
		rc(ADDR_DATA, 8'h3c, "rx buf");
		rc(8'h77, 8'h00, "unmapped");
		wr(ADDR_DATA, 8'h11);
		rc(ADDR_STATUS, 8'h80, "blocked");
		@(posedge clock);
		ge <= 1'b0;
		@(negedge clock);
		@(negedge clock);
		chk("masked", {7'h00, irq}, 8'h00);
		@(posedge clock);
		ge <= 1'b1;
		wr(ADDR_STATUS, 8'h83);
		rc(ADDR_STATUS, 8'h80, "reserved");
		wr(ADDR_STATUS, 8'h00);
		rc(ADDR_STATUS, 8'h00, "cleared");
		wr(ADDR_DATA, 8'h5a);
		wr(ADDR_DATA, 8'hff);
		wirq();
		rc(ADDR_STATUS, 8'hc0, "collision");
		chk("peer rx", rx, 8'h5a);
		wr(ADDR_STATUS, 8'h00);
		$display("test master done");
	endtask : t_master
	task automatic t_fault();
		@(posedge clock);
		soe <= 1'b0;
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		rc(ADDR_STATUS, 8'h10, "fault");
		chk("fault irq", {7'h00, irq}, 8'h01);
		@(posedge clock);
		soe <= 1'b1;
		ss_n <= 1'b1;
		// let the synchronised select settle high before the clear
		repeat (3) @(posedge clock);
		wr(ADDR_STATUS, 8'h08);
		ss_n <= 1'b0;
		repeat (4) @(posedge clock);
		rc(ADDR_STATUS, 8'h08, "no fault");
		chk("ss oe", {7'h00, select_output_enable_n}, 8'h00);
		@(posedge clock);
		ss_n <= 1'b1;
		wr(ADDR_STATUS, 8'h00);
		$display("test fault done");
	endtask : t_fault
	// overrun: second byte lands while done is still set
	task automatic t_slave();
		logic [7:0] got;
		@(posedge clock);
		ms <= 1'b0;
		wr(ADDR_STATUS, 8'h08);
		rc(ADDR_STATUS, 8'h08, "disable");
		chk("ss oe", {7'h00, select_output_enable_n}, 8'h01);
		@(posedge clock);
		ss_n <= 1'b0;
		repeat (8) @(posedge clock);
		wr(ADDR_DATA, 8'hc3);
		rc(ADDR_STATUS, 8'h0c, "slave txfull");
		chk("slave oe", {5'h00, sckoe_n, mosioe_n, misooe_n}, 8'h06);
		sbyte(8'h5a, got);
		chk("slave tx", got, 8'hc3);
		sbyte(8'h96, got);
		repeat (8) @(posedge clock);
		ss_n <= 1'b1;
		rc(ADDR_STATUS, 8'ha8, "overrun");
		rc(ADDR_DATA, 8'h5a, "rx kept");
		$display("test slave done");
	endtask : t_slave
	// reset again in mid run with flags, interrupt and buffer loaded
	task automatic t_rerun();
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		rc(ADDR_STATUS, RST_STATUS, "status again");
		rc(ADDR_DATA, RST_DATA, "data again");
		chk("irq again", {7'h00, irq}, 8'h00);
		$display("test rerun done");
	endtask : t_rerun
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		t_reset();
		t_master();
		t_fault();
		t_slave();
		t_rerun();
		final_report();
	end
	// about twenty times the expected run
	initial begin
		repeat (8000) @(posedge clock);
		miscompares++;
		final_report();
	end
endmodule : spi_status_and_data_path_tb
